// *** bench/async_desc_engine_sva.sv ***
// port checker for the descriptor engine
`timescale 1ns/1ps
module async_desc_engine_sva #(
  parameter int DATA_W     = 64,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic                              i_clock,
  input wire logic                              i_rstn,
  input wire logic [async_desc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0]                       i_wdata,
  input wire logic                              i_write,
  input wire logic                              i_read,
  input wire logic [31:0]                       o_rdata,
  input wire async_desc_pkg::token_t            o_token,
  input wire logic                              o_token_valid,
  input wire logic                              i_resp_valid,
  input wire async_desc_pkg::resp_t             i_resp,
  input wire logic                              o_mem_we,
  input wire logic [async_desc_pkg::PTR_W-1:0]  o_mem_addr,
  input wire logic [DATA_W-1:0]                 o_mem_wdata,
  input wire logic                              i_mem_ready
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  logic        go;
  logic [31:0] dw0;
  logic [31:0] dw1;
  logic [31:0] dw2;
  assign go = i_write && i_addr == async_desc_pkg::OFS_CTRL && i_wdata[0];
  // shadow of software fields; no reset, tokens only follow writes
  always_ff @(posedge i_clock)
  begin
    if (i_write && i_addr == async_desc_pkg::OFS_DW0) dw0 <= i_wdata;
    if (i_write && i_addr == async_desc_pkg::OFS_DW1) dw1 <= i_wdata;
    if (i_write && i_addr == async_desc_pkg::OFS_DW2) dw2 <= i_wdata;
  end
  a_token_address: assert property (o_token_valid |->
    o_token.function_address == dw1[9:3] && o_token.endpoint_number == {dw1[2:0], dw0[31]})
    else $error("token address differs from descriptor");
  a_token_kind: assert property (o_token_valid |->
    o_token.split == dw1[14] && o_token.is_bulk == (dw1[13:12] == 2'h2))
    else $error("token kind differs from descriptor");
  a_token_pid: assert property (o_token_valid |->
    o_token.pid == dw1[11:10]
    || (o_token.pid == async_desc_pkg::PID_PING && dw1[11:10] == 2'h0 && !dw1[14]))
    else $error("token pid not from descriptor");
  a_token_cause: assert property (o_token_valid |-> $past(go, 2) || $past(i_resp_valid, 2))
    else $error("token without go or reply");
  a_token_pulse: assert property (o_token_valid |=> !o_token_valid)
    else $error("token valid longer than one cycle");
  a_token_hold: assert property (!o_token_valid |-> $stable(o_token))
    else $error("token changed without valid");
  a_mem_hold: assert property (o_mem_we && !i_mem_ready |=>
    o_mem_we && $stable(o_mem_addr) && $stable(o_mem_wdata))
    else $error("memory write dropped while stalled");
  a_mem_base: assert property (o_mem_we |-> o_mem_addr >= dw2[23:8])
    else $error("memory address below payload pointer");
  a_rdata_idle: assert property (!$past(i_read) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_reset_quiet: assert property ($rose(i_rstn) |-> !o_token_valid && !o_mem_we)
    else $error("outputs active after reset");
  c_split: cover property (o_token_valid && o_token.split);
  c_stall: cover property (o_mem_we && !i_mem_ready);
  c_error: cover property (i_resp_valid && i_resp.code == async_desc_pkg::RESP_ERROR);
endmodule : async_desc_engine_sva
bind async_desc_engine async_desc_engine_sva #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) i_sva (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
  .i_read(i_read), .o_rdata(o_rdata), .o_token(o_token), .o_token_valid(o_token_valid),
  .i_resp_valid(i_resp_valid), .i_resp(i_resp), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata), .i_mem_ready(i_mem_ready));

// *** bench/async_desc_engine_tb.sv ***
// self-checking bench for the descriptor engine
`timescale 1ns/1ps
module async_desc_engine_tb;
  logic                       i_clock = 1'b0;
  logic                       i_rstn = 1'b0;
  logic                       i_write = 1'b0;
  logic                       i_read = 1'b0;
  logic                       i_rx_valid = 1'b0;
  logic                       i_mem_ready = 1'b0;
  logic [7:0]                 i_addr = 8'h00;
  logic [31:0]                i_wdata = 32'h0;
  logic [63:0]                i_rx_data = 64'h0;
  logic                       i_resp_valid, o_token_valid, o_rx_ready, o_mem_we;
  logic [31:0]                o_rdata, rd_data;
  logic [63:0]                o_mem_wdata;
  logic [15:0]                o_mem_addr;
  async_desc_pkg::token_t     o_token, last_tok;
  async_desc_pkg::resp_t      i_resp;
  async_desc_pkg::resp_code_t code = async_desc_pkg::RESP_ACK;
  logic [10:0]                nbytes = 11'h004;
  logic [7:0]                 delay = 8'h02, tok_cnt, cnt0;
  int                         bad_count = 0, checks_done = 0;
  always #50 i_clock = ~i_clock;
  async_desc_engine i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .o_token(o_token), .o_token_valid(o_token_valid), .i_resp_valid(i_resp_valid),
    .i_resp(i_resp), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .i_mem_ready(i_mem_ready));
  usb_function_model i_far (.i_clock(i_clock), .i_rstn(i_rstn), .i_token_valid(o_token_valid),
    .i_token(o_token), .i_code(code), .i_bytes(nbytes), .i_delay(delay),
    .o_resp_valid(i_resp_valid), .o_resp(i_resp), .o_token_count(tok_cnt),
    .o_last_token(last_tok));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 rd_data = o_rdata;
  endtask : rd
  // software side: multiplier never 00, nak fields equal, pointer from cpu address
  task automatic setd(input logic [3:0] ep, input logic [1:0] pid, typ, mult,
                      input logic sp, input logic [14:0] req, input logic [3:0] rl);
    logic [31:0] w [4];
    w[0] = {ep[0], mult, 11'h008, req, 3'h1};
    w[1] = {17'h0, sp, typ, pid, 3'h5, ep, ep[3:1]};
    w[2] = {3'h0, rl, 1'h0, 16'((32'h0600 - 32'h0400) >> 3), 8'h00};
    w[3] = {1'h1, 6'h0, 2'h3, rl, 19'h0};
    for (int i = 0; i < 4; i++)
      wr(8'(async_desc_pkg::OFS_DW0 + 4 * i), w[i]);
  endtask : setd
  task automatic go_cmd;
    cnt0 = tok_cnt;
    wr(async_desc_pkg::OFS_CTRL, 32'h1);
  endtask : go_cmd
  task automatic idle_wait;
    for (int n = 0; n < 80; n++)
    begin
      rd(async_desc_pkg::OFS_CTRL);
      if (rd_data === 32'h2) break;
    end
    // a descriptor that never settles counts against the run
    check(rd_data, 32'h2);
  endtask : idle_wait
  task automatic run_dw3(input logic [31:0] exp);
    go_cmd();
    idle_wait();
    rd(async_desc_pkg::OFS_DW3);
    check(rd_data, exp);
  endtask : run_dw3
  task automatic t_reset;
    logic [31:0] exp [6];
    exp = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0};
    for (int i = 0; i < 6; i++)
    begin
      rd(8'(4 * i));
      check(rd_data, exp[i]);
    end
    $display("reset values done");
  endtask : t_reset
  task automatic t_tokens;
    for (int k = 0; k < 3; k++)
    begin
      setd(4'(k + 5), 2'(k), (k == 2) ? 2'h0 : 2'h2, 2'h1, 1'b0, 15'h040, 4'h0);
      run_dw3(32'h0180_0004);
      check(last_tok, {1'b0, 1'(k != 2), 2'(k), 3'h5, 4'(k + 5), 4'(k + 5)});
      check(tok_cnt - cnt0, 8'h01);
      rd(async_desc_pkg::OFS_DW0);
      check(rd_data[0], 1'b0);
    end
    $display("token fields done");
  endtask : t_tokens
  task automatic t_mult;
    nbytes = 11'h008;
    setd(4'h3, 2'h1, 2'h2, 2'h2, 1'b0, 15'h010, 4'h0);
    run_dw3(32'h0180_0010);
    check(tok_cnt - cnt0, 8'h02);
    setd(4'h3, 2'h1, 2'h2, 2'h2, 1'b1, 15'h020, 4'h0);
    run_dw3(32'h8180_0008);
    check(tok_cnt - cnt0, 8'h01);
    $display("multiplier done");
  endtask : t_mult
  task automatic t_nak;
    code = async_desc_pkg::RESP_NAK;
    setd(4'h1, 2'h1, 2'h2, 2'h1, 1'b0, 15'h010, 4'h2);
    run_dw3(32'h8188_0000);
    run_dw3(32'h8180_0000);
    rd(async_desc_pkg::OFS_DW0);
    check(rd_data[0], 1'b0);
    setd(4'h1, 2'h0, 2'h2, 2'h1, 1'b0, 15'h010, 4'h0);
    run_dw3(32'h8580_0000);
    go_cmd();
    idle_wait();
    check(last_tok.pid, async_desc_pkg::PID_PING);
    rd(async_desc_pkg::OFS_DW0);
    check(rd_data[0], 1'b1);
    $display("nak handling done");
  endtask : t_nak
  task automatic t_err;
    code = async_desc_pkg::RESP_ERROR;
    setd(4'h2, 2'h1, 2'h2, 2'h1, 1'b0, 15'h010, 4'h0);
    run_dw3(32'h1000_0000);
    check(tok_cnt - cnt0, 8'h03);
    code = async_desc_pkg::RESP_STALL;
    setd(4'h2, 2'h1, 2'h2, 2'h1, 1'b0, 15'h010, 4'h0);
    run_dw3(32'h4180_0000);
    $display("error handling done");
  endtask : t_err
  task automatic t_mem;
    int acc;
    int k;
    acc = 0;
    k = 0;
    code = async_desc_pkg::RESP_ACK;
    nbytes = 11'h004;
    delay = 8'h50;
    setd(4'h4, 2'h1, 2'h2, 2'h1, 1'b0, 15'h040, 4'h0);
    go_cmd();
    i_rx_valid <= 1'b1;
    i_rx_data <= 64'hA5A5_0000_0000_0000;
    // memory stalls, so the buffer must fill and then refuse
    for (int n = 0; n < 12 && o_rx_ready !== 1'b0; n++)
    begin
      @(posedge i_clock);
      if (o_rx_ready === 1'b1) acc++;
      i_rx_data <= 64'hA5A5_0000_0000_0000 | acc;
    end
    i_rx_valid <= 1'b0;
    check(acc >= 8 && o_rx_ready === 1'b0, 1'b1);
    i_mem_ready <= 1'b1;
    for (int n = 0; n < 40 && k < acc; n++)
    begin
      @(posedge i_clock);
      if (o_mem_we === 1'b1)
      begin
        check(o_mem_addr, 16'(16'h0040 + k));
        check(o_mem_wdata, 64'hA5A5_0000_0000_0000 | k);
        k++;
      end
    end
    check(k, acc);
    idle_wait();
    $display("payload path done");
  endtask : t_mem
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    #3000000;
    bad_count++;
    final_report();
  end
  initial
  begin
    repeat (12) @(posedge i_clock);
    i_rstn <= 1'b1;
    t_reset();
    t_tokens();
    t_mult();
    t_nak();
    t_err();
    t_mem();
    final_report();
  end
endmodule : async_desc_engine_tb

// *** bench/usb_function_model.sv ***
// downstream function model answering each token with one handshake
`timescale 1ns/1ps
module usb_function_model (
  // clock and reset
  input  wire logic                       i_clock,
  input  wire logic                       i_rstn,
  // token from the engine
  input  wire logic                       i_token_valid,
  input  wire async_desc_pkg::token_t     i_token,
  // reply chosen by the bench
  input  wire async_desc_pkg::resp_code_t i_code,
  input  wire logic [10:0]                i_bytes,
  input  wire logic [7:0]                 i_delay,
  // reply towards the engine
  output logic                            o_resp_valid,
  output async_desc_pkg::resp_t           o_resp,
  output logic [7:0]                      o_token_count,
  output async_desc_pkg::token_t          o_last_token
);
  logic       pending;
  logic [7:0] wait_left;
  initial
  begin
    {o_resp_valid, o_resp, o_token_count, o_last_token, pending, wait_left} = '0;
  end
  always @(posedge i_clock)
  begin
    o_resp_valid <= 1'b0;
    // released reply lines flip so a stale value never looks current
    if (o_resp_valid) o_resp <= ~o_resp;
    if (!i_rstn) pending <= 1'b0;
    else if (i_token_valid)
    begin
      pending <= 1'b1;
      wait_left <= i_delay;
      o_token_count <= o_token_count + 8'h01;
      o_last_token <= i_token;
    end
    else if (pending && wait_left == 8'h00)
    begin
      pending <= 1'b0;
      o_resp_valid <= 1'b1;
      o_resp <= {i_code, i_bytes};
    end
    else if (pending) wait_left <= wait_left - 8'h01;
  end
endmodule : usb_function_model

// *** hdl/async_desc_engine.sv ***
// descriptor word store and execution engine for bulk and control transfers
`timescale 1ns/1ps
// What this block does
// - writes bytes actually moved into the bytes-done count
// - keeps running partial byte totals between packets of one execution
// - nak retry count is ignored when the reload value is zero
// - payload pointer is an internal memory word address
// - hub relay flag low runs high-speed, high runs split transaction
// - token code from descriptor; ping code placed by hardware, or by software writing 11 into the token field
// - token addressed to the 7-bit function address
// - endpoint number joins three upper bits with one lower bit
// - packet multiplier sets packets per execution, high-speed only
// - entry-armed flag clears when descriptor completes, when the nak count expires or on fatal error
// - error count 11 gives three tries, then a transaction error
// - bytes-requested count bounds total payload, up to 32 kbytes
module async_desc_engine #(
  parameter int DATA_W     = 64,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic                                     i_clock,
  input  wire logic                                     i_rstn,
  // register port
  input  wire logic [async_desc_pkg::ADDR_W-1:0]        i_addr,
  input  wire logic [31:0]                              i_wdata,
  input  wire logic                                     i_write,
  input  wire logic                                     i_read,
  output logic      [31:0]                              o_rdata,
  // token issue towards the link
  output async_desc_pkg::token_t                        o_token,
  output logic                                          o_token_valid,
  // handshake result from the link
  input  wire logic                                     i_resp_valid,
  input  wire async_desc_pkg::resp_t                    i_resp,
  // received payload stream
  input  wire logic                                     i_rx_valid,
  input  wire logic [DATA_W-1:0]                        i_rx_data,
  output logic                                          o_rx_ready,
  // internal memory write port
  output logic                                          o_mem_we,
  output logic      [async_desc_pkg::PTR_W-1:0]         o_mem_addr,
  output logic      [DATA_W-1:0]                        o_mem_wdata,
  input  wire logic                                     i_mem_ready
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT  = 3'b100
  } state_t;

  localparam int CW = async_desc_pkg::COUNT_W;
  localparam int NW = async_desc_pkg::NAK_W;
  localparam int MW = async_desc_pkg::MULT_W;
  localparam int EW = async_desc_pkg::CERR_W;
  localparam int PW = async_desc_pkg::PTR_W;

  logic [31:0]       desc [async_desc_pkg::DESC_WORDS];
  state_t            state;
  logic [MW-1:0]     packets_left;
  logic [PW-1:0]     word_offset;

  // word decode shared by read and write paths
  function automatic logic [1:0] word_index(input logic [async_desc_pkg::ADDR_W-1:0] a);
    word_index = a[3:2];
  endfunction : word_index

  function automatic logic desc_hit(input logic [async_desc_pkg::ADDR_W-1:0] a);
    desc_hit = (a < async_desc_pkg::OFS_CTRL) && (a[1:0] == 2'h0);
  endfunction : desc_hit

  // field views
  logic                   f_valid;
  logic                   f_active;
  logic                   f_split;
  logic                   f_bulk;
  logic [1:0]             f_token;
  logic [1:0]             f_type;
  logic [6:0]             f_faddr;
  logic [3:0]             f_endpoint_number;
  logic [MW-1:0]          f_mult;
  logic [MW-1:0]          eff_mult;
  logic [10:0]            f_mpl;
  logic [CW-1:0]          f_requested;
  logic [CW-1:0]          f_done;
  logic [NW-1:0]          f_reload;
  logic [NW-1:0]          f_nak_retry_count;
  logic [EW-1:0]          f_cerr;
  logic [PW-1:0]          f_ptr;
  logic                   f_ping;

  assign f_valid     = desc[0][async_desc_pkg::DW0_VALID_BIT];
  assign f_active    = desc[3][async_desc_pkg::DW3_ACTIVE_BIT];
  assign f_split     = desc[1][async_desc_pkg::DW1_SPLIT_BIT];
  assign f_type      = desc[1][async_desc_pkg::DW1_TYPE_LSB +: 2];
  assign f_bulk      = (f_type == async_desc_pkg::XFER_BULK);
  assign f_token     = desc[1][async_desc_pkg::DW1_TOKEN_LSB +: 2];
  assign f_faddr     = desc[1][async_desc_pkg::DW1_FADDR_LSB +: async_desc_pkg::FADDR_W];
  assign f_endpoint_number     = {desc[1][async_desc_pkg::DW1_ENDPOINT_NUMBER_HI_LSB +: async_desc_pkg::ENDPOINT_NUMBER_HI_W],
                        desc[0][async_desc_pkg::DW0_ENDPOINT_NUMBER_LO_BIT]};
  assign f_mult      = desc[0][async_desc_pkg::DW0_MULT_LSB +: MW];
  assign f_mpl       = desc[0][async_desc_pkg::DW0_MPL_LSB +: async_desc_pkg::MPL_W];
  assign f_requested = desc[0][async_desc_pkg::DW0_REQ_LSB +: CW];
  assign f_done      = desc[3][async_desc_pkg::DW3_DONE_LSB +: CW];
  assign f_reload    = desc[2][async_desc_pkg::DW2_RELOAD_LSB +: NW];
  assign f_nak_retry_count    = desc[3][async_desc_pkg::DW3_NAK_RETRY_COUNT_LSB +: NW];
  assign f_cerr      = desc[3][async_desc_pkg::DW3_CERR_LSB +: EW];
  assign f_ptr       = desc[2][async_desc_pkg::DW2_PTR_LSB +: PW];
  assign f_ping      = desc[3][async_desc_pkg::DW3_PING_BIT];

  // multiplier applies to high-speed only; a split runs one packet
  assign eff_mult = f_split ? MW'(1) : f_mult;

  // response evaluation
  logic [CW:0]   sum_done;
  logic [CW-1:0] next_done;
  logic          resp_take;
  logic          is_ack;
  logic          is_nak;
  logic          is_err;
  logic          is_stall;
  logic          xfer_complete;
  logic          nak_expired;
  logic          err_exhausted;
  logic          hs_out;

  assign resp_take = (state == ST_WAIT) && i_resp_valid;
  assign is_ack    = (i_resp.code == async_desc_pkg::RESP_ACK);
  assign is_nak    = (i_resp.code == async_desc_pkg::RESP_NAK);
  assign is_err    = (i_resp.code == async_desc_pkg::RESP_ERROR);
  assign is_stall  = (i_resp.code == async_desc_pkg::RESP_STALL);
  assign hs_out    = !f_split && (f_token == async_desc_pkg::PID_OUT);

  // running total; intermediate sums stay visible between packets
  assign sum_done  = {1'b0, f_done} + {{(CW+1-async_desc_pkg::MPL_W){1'b0}}, i_resp.bytes};
  assign next_done = sum_done[CW] ? {CW{1'b1}} : sum_done[CW-1:0];
  // a short packet or reaching the requested depth ends the descriptor
  assign xfer_complete = (next_done >= f_requested) || (i_resp.bytes < f_mpl);
  // reload zero means naks never disarm
  assign nak_expired   = (f_reload != '0) && (f_nak_retry_count <= NW'(1));
  assign err_exhausted = (f_cerr <= EW'(1));

  logic go;
  assign go = i_write && (i_addr == async_desc_pkg::OFS_CTRL)
              && i_wdata[async_desc_pkg::CTRL_GO_BIT];

  // execution state machine
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      state        <= ST_IDLE;
      packets_left <= '0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (go && f_valid && f_active)
          begin
            state        <= ST_ISSUE;
            packets_left <= eff_mult;
          end
        end
        ST_ISSUE:
          state <= ST_WAIT;
        ST_WAIT:
        begin
          if (resp_take)
          begin
            state <= ST_IDLE;
            if (is_ack && !xfer_complete && (packets_left > MW'(1)))
            begin
              state        <= ST_ISSUE;
              packets_left <= packets_left - 1'b1;
            end
            else if (is_err && !err_exhausted)
              state <= ST_ISSUE;
          end
        end
      endcase
    end
  end

  // descriptor store: software writes only while idle, so hardware updates never collide
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      for (int i = 0; i < async_desc_pkg::DESC_WORDS; i++)
        desc[i] <= '0;
    end
    else if (state == ST_IDLE)
    begin
      if (i_write && desc_hit(i_addr))
        desc[word_index(i_addr)] <= i_wdata;
    end
    else if (resp_take)
    begin
      if (is_ack)
      begin
        desc[3][async_desc_pkg::DW3_DONE_LSB +: CW] <= next_done;
        desc[3][async_desc_pkg::DW3_NAK_RETRY_COUNT_LSB +: NW] <= f_reload;
        desc[3][async_desc_pkg::DW3_PING_BIT] <= 1'b0;
        if (xfer_complete)
        begin
          desc[0][async_desc_pkg::DW0_VALID_BIT] <= 1'b0;
          desc[3][async_desc_pkg::DW3_ACTIVE_BIT] <= 1'b0;
        end
      end
      else if (is_nak)
      begin
        // high-speed out naks switch the next attempt to a ping
        if (hs_out)
          desc[3][async_desc_pkg::DW3_PING_BIT] <= 1'b1;
        if (f_reload != '0)
        begin
          desc[3][async_desc_pkg::DW3_NAK_RETRY_COUNT_LSB +: NW] <= f_nak_retry_count - 1'b1;
          if (nak_expired)
            desc[0][async_desc_pkg::DW0_VALID_BIT] <= 1'b0;
        end
      end
      else if (is_err)
      begin
        if (f_cerr != '0)
          desc[3][async_desc_pkg::DW3_CERR_LSB +: EW] <= f_cerr - 1'b1;
        if (err_exhausted)
        begin
          desc[3][async_desc_pkg::DW3_XERR_BIT] <= 1'b1;
          desc[3][async_desc_pkg::DW3_ACTIVE_BIT] <= 1'b0;
          desc[0][async_desc_pkg::DW0_VALID_BIT] <= 1'b0;
        end
      end
      else if (is_stall)
      begin
        desc[3][async_desc_pkg::DW3_HALT_BIT] <= 1'b1;
        desc[3][async_desc_pkg::DW3_ACTIVE_BIT] <= 1'b0;
        desc[0][async_desc_pkg::DW0_VALID_BIT] <= 1'b0;
      end
    end
  end

  // token build
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_token       <= '0;
      o_token_valid <= 1'b0;
    end
    else
    begin
      o_token_valid <= (state == ST_ISSUE);
      if (state == ST_ISSUE)
      begin
        o_token.split            <= f_split;
        o_token.is_bulk          <= f_bulk;
        // ping code from the ping state, or from software writing 11 into the token field
        o_token.pid              <= (hs_out && f_ping) ? async_desc_pkg::PID_PING
                                    : async_desc_pkg::pid_t'(f_token);
        o_token.function_address <= f_faddr;
        o_token.endpoint_number  <= f_endpoint_number;
      end
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      o_rdata <= '0;
    else if (i_read)
    begin
      if (desc_hit(i_addr))
        o_rdata <= desc[word_index(i_addr)];
      else if (i_addr == async_desc_pkg::OFS_CTRL)
        o_rdata <= {28'h0000000, state, 1'b0};
      else
        o_rdata <= '0;
    end
    else
      o_rdata <= '0;
  end

  // payload path into internal memory
  logic              fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_ready;

  // the memory stage takes a new word only when its slot is empty or drained
  assign fifo_ready = !o_mem_we || i_mem_ready;

  desc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clock     (i_clock),
    .i_rstn      (i_rstn),
    .i_in_valid  (i_rx_valid),
    .i_in_data   (i_rx_data),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_ready)
  );

  // memory write stage; address counts memory words, not cpu bytes
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_mem_we    <= 1'b0;
      o_mem_addr  <= '0;
      o_mem_wdata <= '0;
      word_offset <= '0;
    end
    else
    begin
      if (state == ST_IDLE && go)
        word_offset <= PW'(f_done >> async_desc_pkg::BYTE_SHIFT);
      if (fifo_ready)
      begin
        o_mem_we <= fifo_valid;
        if (fifo_valid)
        begin
          o_mem_addr  <= f_ptr + word_offset;
          o_mem_wdata <= fifo_data;
          word_offset <= word_offset + 1'b1;
        end
      end
    end
  end

endmodule : async_desc_engine

// *** hdl/async_desc_pkg.sv ***
// shared constants and carriers for the asynchronous descriptor engine
package async_desc_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_DW0     = 8'h00;
  localparam logic [7:0] OFS_DW1     = 8'h04;
  localparam logic [7:0] OFS_DW2     = 8'h08;
  localparam logic [7:0] OFS_DW3     = 8'h0C;
  localparam logic [7:0] OFS_CTRL    = 8'h10;
  localparam int         DESC_WORDS  = 4;
  localparam int         ADDR_W      = 8;

  // word 0 fields
  localparam int DW0_ENDPOINT_NUMBER_LO_BIT = 31;
  localparam int DW0_MULT_LSB     = 29;
  localparam int MULT_W           = 2;
  localparam int DW0_MPL_LSB      = 18;
  localparam int MPL_W            = 11;
  localparam int DW0_REQ_LSB      = 3;
  localparam int COUNT_W          = 15;
  localparam int DW0_VALID_BIT    = 0;

  // word 1 fields
  localparam int DW1_SPLIT_BIT    = 14;
  localparam int DW1_TYPE_LSB     = 12;
  localparam int DW1_TOKEN_LSB    = 10;
  localparam int DW1_FADDR_LSB    = 3;
  localparam int FADDR_W          = 7;
  localparam int DW1_ENDPOINT_NUMBER_HI_LSB = 0;
  localparam int ENDPOINT_NUMBER_HI_W       = 3;

  // word 2 fields
  localparam int DW2_RELOAD_LSB   = 25;
  localparam int NAK_W            = 4;
  localparam int DW2_PTR_LSB      = 8;
  localparam int PTR_W            = 16;

  // word 3 fields
  localparam int DW3_ACTIVE_BIT   = 31;
  localparam int DW3_HALT_BIT     = 30;
  localparam int DW3_XERR_BIT     = 28;
  localparam int DW3_PING_BIT     = 26;
  localparam int DW3_CERR_LSB     = 23;
  localparam int CERR_W           = 2;
  localparam int DW3_NAK_RETRY_COUNT_LSB   = 19;
  localparam int DW3_DONE_LSB     = 0;

  // control register bits
  localparam int CTRL_GO_BIT      = 0;

  // memory word holds eight bytes
  localparam int BYTE_SHIFT       = 3;

  typedef enum logic [1:0] {
    PID_OUT   = 2'h0,
    PID_IN    = 2'h1,
    PID_SETUP = 2'h2,
    PID_PING  = 2'h3
  } pid_t;

  typedef enum logic [1:0] {
    XFER_CONTROL = 2'h0,
    XFER_BULK    = 2'h2
  } xfer_type_t;

  typedef enum logic [1:0] {
    RESP_ACK   = 2'h0,
    RESP_NAK   = 2'h1,
    RESP_ERROR = 2'h2,
    RESP_STALL = 2'h3
  } resp_code_t;

  typedef struct packed {
    logic                       split;
    logic                       is_bulk;
    pid_t                       pid;
    logic [FADDR_W-1:0]         function_address;
    logic [ENDPOINT_NUMBER_HI_W:0]        endpoint_number;
  } token_t;

  typedef struct packed {
    resp_code_t                 code;
    logic [MPL_W-1:0]           bytes;
  } resp_t;

endpackage : async_desc_pkg

// *** hdl/desc_fifo.sv ***
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module desc_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;
  assign o_out_valid = (count != '0);
  assign o_out_data  = store[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      count      <= '0;
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      o_in_ready <= 1'b0;
    end
    else
    begin
      count      <= next_count;
      // registered ready: full is known one edge ahead
      o_in_ready <= (next_count != (PW+1)'(DEPTH));
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (push)
      store[wr_ptr] <= i_in_data;
  end

endmodule : desc_fifo
